// >>> rssd_pkg.sv
// Purpose: shared constants and types of the rotate/subtract/skip datapath
// Assumes: 8-bit data, operations coded by the instruction decoder
// Notes:   flag vector order is watchdog, power-down, wrap, zero, half, carry
package rssd_pkg;

	localparam int unsigned DATA_W  = 8;
	localparam int unsigned OP_W    = 5;
	localparam int unsigned FLAG_W  = 6;

	// flag positions
	localparam int unsigned FLAG_C    = 0;
	localparam int unsigned FLAG_HALF = 1;
	localparam int unsigned FLAG_Z    = 2;
	localparam int unsigned FLAG_WRAP = 3;
	localparam int unsigned FLAG_PD   = 4;
	localparam int unsigned FLAG_WDOG = 5;

	localparam logic [DATA_W-1:0] ACC_RESET   = 8'h00;
	localparam logic [FLAG_W-1:0] FLAGS_RESET = 6'h00;
	localparam logic [DATA_W-1:0] ALL_ONES    = 8'hFF;
	localparam logic [DATA_W-1:0] ONE         = 8'h01;

	// execute cycles
	localparam int unsigned CYC_NORMAL = 1;
	localparam int unsigned CYC_SKIP   = 2;

	typedef enum logic [OP_W-1:0] {
		rotate_left_via_carry_mem        = 5'h00,
		rotate_left_via_carry_to_accum   = 5'h01,
		rotate_right_mem                 = 5'h02,
		rotate_right_to_accum            = 5'h03,
		right_rotate_via_carry_mem       = 5'h04,
		right_rotate_via_carry_to_accum  = 5'h05,
		minus_with_borrow                = 5'h06,
		minus_with_borrow_to_mem         = 5'h07,
		minus_operand                    = 5'h08,
		minus_operand_to_mem             = 5'h09,
		minus_immediate                  = 5'h0A,
		decrement_then_skip_zero         = 5'h0B,
		decrement_then_skip_zero_accum   = 5'h0C,
		increment_then_skip_zero         = 5'h0D,
		increment_then_skip_zero_accum   = 5'h0E,
		bit_test_skip_nonzero            = 5'h0F,
		fill_byte                        = 5'h10,
		set_bit                          = 5'h11,
		nibble_exchange                  = 5'h12
	} rssd_op_t;

	typedef enum logic [0:0] {
		RSSD_RUN   = 1'b0,
		RSSD_DUMMY = 1'b1
	} rssd_state_t;

endpackage

// >>> rssd_sub.sv
// Purpose: 8-bit adder for subtract forms, a + ~b + cin with flags
// Assumes: caller inverts nothing; inversion done here
// Notes:   purely combinational
`timescale 1ns/1ps
module rssd_sub
	import rssd_pkg::*;
(
	input  wire logic [DATA_W-1:0] a,
	input  wire logic [DATA_W-1:0] b,
	input  wire logic              cin,
	output logic      [DATA_W-1:0] sum,
	output logic                   cout,
	output logic                   half,
	output logic                   wrap
);

	logic [4:0] low;
	logic [8:0] full;
	logic [7:0] nb;

	always_comb begin
		nb   = ~b;
		low  = {1'b0, a[3:0]} + {1'b0, nb[3:0]} + {4'h0, cin};
		full = {1'b0, a} + {1'b0, nb} + {8'h00, cin};
		sum  = full[7:0];
		cout = full[8];
		half = low[4];
		wrap = (a[7] == nb[7]) && (full[7] != a[7]);
	end

endmodule

// >>> rssd_core.sv
// Purpose: execute datapath for rotate, subtract, skip, set and swap ops
// Assumes: decoder gives op, operand, immediate, bit index, start pulse
// Notes:   result is registered; skip holds a dummy cycle
//
// Overview of operation
// - rotate left through carry, result to memory
// - same left rotate, result to accumulator
// - rotate memory right, bit 0 wraps
// - right rotate into accumulator, memory kept
// - rotate right through carry, result to memory
// - same right rotate, result to accumulator
// - subtract with borrow, four arithmetic flags
// - subtract memory without borrow, four flags
// - subtract immediate into accumulator, four flags
// - true skip discards prefetch, two cycles
// - decrement memory, skip when zero
// - decrement into accumulator, skip when zero
// - increment memory, skip when zero
// - increment into accumulator, skip when zero
// - skip when selected memory bit set
// - fill memory byte with all ones
// - set selected memory bit to one
// - exchange nibbles of memory byte
`timescale 1ns/1ps
module rssd_core
	import rssd_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic              start,
	input  wire logic [OP_W-1:0]   op,
	input  wire logic [DATA_W-1:0] mem_rd_data,
	input  wire logic [DATA_W-1:0] imm,
	input  wire logic [2:0]        bit_sel,
	output logic      [DATA_W-1:0] acc,
	output logic      [FLAG_W-1:0] flags,
	output logic                   mem_wr,
	output logic      [DATA_W-1:0] mem_wr_data,
	output logic                   discard_prefetch,
	output logic                   busy,
	output logic                   done
);

	// ************************************************************
	// helper functions
	// ************************************************************
	function automatic logic is_zero(input logic [DATA_W-1:0] v);
		return v == 8'h00;
	endfunction

	function automatic logic [DATA_W-1:0] bit_mask(input logic [2:0] i);
		return ONE << i;
	endfunction

	// ************************************************************
	// subtractor
	// ************************************************************
	logic [DATA_W-1:0] sub_b;
	logic              sub_cin;
	logic [DATA_W-1:0] sub_sum;
	logic              sub_cout;
	logic              sub_half;
	logic              sub_wrap;

	always_comb begin
		sub_b   = mem_rd_data;
		sub_cin = 1'b1;
		case (rssd_op_t'(op))
			minus_with_borrow,
			minus_with_borrow_to_mem: begin
				sub_cin = flags[FLAG_C];
			end
			minus_immediate: begin
				sub_b = imm;
			end
			default: begin
				sub_cin = 1'b1;
			end
		endcase
	end

	rssd_sub u_sub (
		.a    (acc),
		.b    (sub_b),
		.cin  (sub_cin),
		.sum  (sub_sum),
		.cout (sub_cout),
		.half (sub_half),
		.wrap (sub_wrap)
	);

	// ************************************************************
	// operation decode
	// ************************************************************
	rssd_state_t       state;
	rssd_state_t       next_state;
	logic [DATA_W-1:0] next_acc;
	logic [FLAG_W-1:0] next_flags;
	logic              next_mem_wr;
	logic [DATA_W-1:0] next_mem_wr_data;
	logic              next_discard;
	logic              next_busy;
	logic              next_done;
	logic [DATA_W-1:0] m;
	logic [DATA_W-1:0] dec_v;
	logic [DATA_W-1:0] inc_v;
	logic              skip;

	always_comb begin
		m                = mem_rd_data;
		dec_v            = m - ONE;
		inc_v            = m + ONE;
		skip             = 1'b0;
		next_state       = state;
		next_acc         = acc;
		next_flags       = flags;
		next_mem_wr      = 1'b0;
		next_mem_wr_data = mem_wr_data;
		next_discard     = 1'b0;
		next_busy        = 1'b0;
		next_done        = 1'b0;
		case (state)
			RSSD_RUN: begin
				if (start) begin
					next_done = 1'b1;
					case (rssd_op_t'(op))
						rotate_left_via_carry_mem: begin
							next_mem_wr      = 1'b1;
							next_mem_wr_data = {m[6:0], flags[FLAG_C]};
							next_flags[FLAG_C] = m[7];
						end
						rotate_left_via_carry_to_accum: begin
							next_acc = {m[6:0], flags[FLAG_C]};
							next_flags[FLAG_C] = m[7];
						end
						rotate_right_mem: begin
							next_mem_wr      = 1'b1;
							next_mem_wr_data = {m[0], m[7:1]};
						end
						rotate_right_to_accum: begin
							next_acc = {m[0], m[7:1]};
						end
						right_rotate_via_carry_mem: begin
							next_mem_wr      = 1'b1;
							next_mem_wr_data = {flags[FLAG_C], m[7:1]};
							next_flags[FLAG_C] = m[0];
						end
						right_rotate_via_carry_to_accum: begin
							next_acc = {flags[FLAG_C], m[7:1]};
							next_flags[FLAG_C] = m[0];
						end
						minus_with_borrow,
						minus_operand,
						minus_immediate: begin
							next_acc = sub_sum;
							next_flags[FLAG_C]    = sub_cout;
							next_flags[FLAG_HALF] = sub_half;
							next_flags[FLAG_Z]    = is_zero(sub_sum);
							next_flags[FLAG_WRAP] = sub_wrap;
						end
						minus_with_borrow_to_mem,
						minus_operand_to_mem: begin
							next_mem_wr      = 1'b1;
							next_mem_wr_data = sub_sum;
							next_flags[FLAG_C]    = sub_cout;
							next_flags[FLAG_HALF] = sub_half;
							next_flags[FLAG_Z]    = is_zero(sub_sum);
							next_flags[FLAG_WRAP] = sub_wrap;
						end
						decrement_then_skip_zero: begin
							next_mem_wr      = 1'b1;
							next_mem_wr_data = dec_v;
							skip             = is_zero(dec_v);
						end
						decrement_then_skip_zero_accum: begin
							next_acc = dec_v;
							skip     = is_zero(dec_v);
						end
						increment_then_skip_zero: begin
							next_mem_wr      = 1'b1;
							next_mem_wr_data = inc_v;
							skip             = is_zero(inc_v);
						end
						increment_then_skip_zero_accum: begin
							next_acc = inc_v;
							skip     = is_zero(inc_v);
						end
						bit_test_skip_nonzero: begin
							skip = m[bit_sel];
						end
						fill_byte: begin
							next_mem_wr      = 1'b1;
							next_mem_wr_data = ALL_ONES;
						end
						set_bit: begin
							next_mem_wr      = 1'b1;
							next_mem_wr_data = m | bit_mask(bit_sel);
						end
						nibble_exchange: begin
							next_mem_wr      = 1'b1;
							next_mem_wr_data = {m[3:0], m[7:4]};
						end
						default: begin
							next_done = 1'b0;
						end
					endcase
					if (skip) begin
						next_discard = 1'b1;
						next_busy    = 1'b1;
						next_done    = 1'b0;
						next_state   = RSSD_DUMMY;
					end
				end
			end
			RSSD_DUMMY: begin
				next_done  = 1'b1;
				next_state = RSSD_RUN;
			end
			default: begin
				next_state = RSSD_RUN;
			end
		endcase
	end

	// ************************************************************
	// state registers
	// ************************************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state            <= RSSD_RUN;
			acc              <= ACC_RESET;
			flags            <= FLAGS_RESET;
			mem_wr           <= 1'b0;
			mem_wr_data      <= ACC_RESET;
			discard_prefetch <= 1'b0;
			busy             <= 1'b0;
			done             <= 1'b0;
		end else begin
			state            <= next_state;
			acc              <= next_acc;
			flags            <= next_flags;
			mem_wr           <= next_mem_wr;
			mem_wr_data      <= next_mem_wr_data;
			discard_prefetch <= next_discard;
			busy             <= next_busy;
			done             <= next_done;
		end
	end

endmodule

// >>> rssd_monitor.sv
// Purpose: port checks of the execute datapath
// Assumes: one clock, async active-low reset
// Notes:   pm holds the operand of the taking edge
`timescale 1ns/1ps
module rssd_monitor
	import rssd_pkg::*;
(
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        start,
	input wire logic [4:0]  op,
	input wire logic [7:0]  mem_rd_data,
	input wire logic [7:0]  imm,
	input wire logic [2:0]  bit_sel,
	input wire logic [7:0]  acc,
	input wire logic [5:0]  flags,
	input wire logic        mem_wr,
	input wire logic [7:0]  mem_wr_data,
	input wire logic        discard_prefetch,
	input wire logic        busy,
	input wire logic        done
);
	logic       tk;
	logic [7:0] pm;
	assign tk = start & ~busy;
	always_ff @(posedge clk) begin
		pm <= mem_rd_data;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_rotl; tk && op == rotate_left_via_carry_mem |=> mem_wr &&
		mem_wr_data == {pm[6:0], $past(flags[0])} && flags[0] == pm[7];
	endproperty
	a_rotl: assert property (p_rotl) else $error("bad rotate");
	property p_rotr; tk && op == rotate_right_to_accum |=> !mem_wr &&
		acc == {pm[0], pm[7:1]} && flags == $past(flags); endproperty
	a_rotr: assert property (p_rotr) else $error("bad rotate");
	property p_minus; tk && op == minus_operand |=> done &&
		acc == $past(acc) - pm && flags[0] == ($past(acc) >= pm);
	endproperty
	a_minus: assert property (p_minus) else $error("bad minus");
	property p_dummy;
		discard_prefetch |-> busy ##1 (done && !busy); endproperty
	a_dummy: assert property (p_dummy) else $error("bad skip");
	property p_inc; tk && op == increment_then_skip_zero |=> mem_wr &&
		mem_wr_data == pm + ONE && discard_prefetch == (pm == ALL_ONES);
	endproperty
	a_inc: assert property (p_inc) else $error("bad inc");
	property p_bit; tk && op == bit_test_skip_nonzero |=> !mem_wr &&
		discard_prefetch == pm[$past(bit_sel)]; endproperty
	a_bit: assert property (p_bit) else $error("bad bit skip");
	property p_fill;
		tk && op == fill_byte |=> mem_wr && mem_wr_data == ALL_ONES;
	endproperty
	a_fill: assert property (p_fill) else $error("bad fill");
	property p_dec; tk && op == decrement_then_skip_zero |=> mem_wr &&
		mem_wr_data == pm - ONE && discard_prefetch == (pm == ONE);
	endproperty
	a_dec: assert property (p_dec) else $error("bad dec");
	property p_setb; tk && op == set_bit |=> mem_wr &&
		mem_wr_data == (pm | (ONE << $past(bit_sel))); endproperty
	a_setb: assert property (p_setb) else $error("bad set bit");
	property p_swap; tk && op == nibble_exchange |=> mem_wr &&
		mem_wr_data == {pm[3:0], pm[7:4]} && flags == $past(flags);
	endproperty
	a_swap: assert property (p_swap) else $error("bad swap");
	property p_keep; $stable(flags[5:4]); endproperty
	a_keep: assert property (p_keep) else $error("status moved");
endmodule

// >>> rssd_dmem.sv
// Purpose: one-byte data memory facing the datapath
// Assumes: combinational read, write on clock
// Notes:   bench loads the operand by writing m
`timescale 1ns/1ps
module rssd_dmem (
	input  wire logic       clk,
	input  wire logic       we,
	input  wire logic [7:0] wd,
	output logic      [7:0] rd
);
	logic [7:0] m = 8'h00;
	assign rd = m;
	always @(posedge clk) begin
		if (we) begin
			m <= wd;
		end
	end
endmodule

// >>> tb_rotate_subtract_skip_datapath.sv
// Purpose: self-checking bench for the execute datapath
// Assumes: one-byte memory model supplies the operand
// Notes:   expect word is acc, memory, flags, skip
`timescale 1ns/1ps
module tb_rotate_subtract_skip_datapath import rssd_pkg::*;;
	logic       clk = 1'b0, arst_n = 1'b0, start = 1'b0;
	logic [4:0] op = 5'h00;
	logic [7:0] imm = 8'h00, mem_rd_data, acc, mem_wr_data;
	logic [2:0] bit_sel = 3'h0;
	logic [5:0] flags;
	logic       mem_wr, discard_prefetch, busy, done;
	int         failures = 0, n_tests = 0, cyc = 0;
	always #2.5 clk = ~clk;
	rssd_core i_rssd_core (.clk(clk), .arst_n(arst_n), .start(start),
		.op(op), .mem_rd_data(mem_rd_data), .imm(imm), .bit_sel(bit_sel),
		.acc(acc), .flags(flags), .mem_wr(mem_wr),
		.mem_wr_data(mem_wr_data), .discard_prefetch(discard_prefetch),
		.busy(busy), .done(done));
	rssd_dmem u_mem (.clk(clk), .we(mem_wr), .wd(mem_wr_data),
		.rd(mem_rd_data));
	task chk(input logic [7:0] g, input logic [7:0] x);
		n_tests++;
		if (g !== x) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task step(input rssd_op_t o, input logic [7:0] v, input logic [31:0] e);
		logic       sk;
		logic [7:0] nc;
		u_mem.m = v;
		op = o;
		imm = v;
		nc = 8'h01;
		start = 1'b1;
		@(posedge clk);
		#1 start = 1'b0;
		sk = discard_prefetch;
		repeat (3) begin
			if (done !== 1'b1) begin
				nc = nc + 8'h01;
				@(posedge clk);
				#1;
			end
		end
		@(posedge clk);
		#1 chk(acc, e[31:24]);
		chk(u_mem.m, e[23:16]);
		chk({2'b00, flags}, e[15:8]);
		chk({7'h00, sk}, e[7:0]);
		chk(nc, e[0] ? 8'(CYC_SKIP) : 8'(CYC_NORMAL));
	endtask
	task t_sub;
		step(minus_operand, 8'h00, 32'h00_00_07_00);
		step(minus_immediate, 8'h01, 32'hFF_01_00_00);
		step(minus_with_borrow, 8'h7F, 32'h7F_7F_09_00);
		step(minus_with_borrow_to_mem, 8'h01, 32'h7F_7E_03_00);
		step(minus_operand_to_mem, 8'h80, 32'h7F_FF_0A_00);
	endtask
	task t_rot;
		step(rotate_left_via_carry_mem, 8'h81, 32'h7F_02_0B_00);
		step(rotate_left_via_carry_to_accum, 8'h40, 32'h81_40_0A_00);
		step(right_rotate_via_carry_mem, 8'h01, 32'h81_00_0B_00);
		step(right_rotate_via_carry_to_accum, 8'h04, 32'h82_04_0A_00);
		step(rotate_right_mem, 8'h01, 32'h82_80_0A_00);
		step(rotate_right_to_accum, 8'h06, 32'h03_06_0A_00);
	endtask
	task t_skip;
		step(decrement_then_skip_zero, 8'h01, 32'h03_00_0A_01);
		step(decrement_then_skip_zero_accum, 8'h01, 32'h00_01_0A_01);
		step(increment_then_skip_zero, 8'hFF, 32'h00_00_0A_01);
		step(increment_then_skip_zero_accum, 8'h05, 32'h06_05_0A_00);
		bit_sel = 3'h7;
		step(bit_test_skip_nonzero, 8'h80, 32'h06_80_0A_01);
		step(bit_test_skip_nonzero, 8'h7F, 32'h06_7F_0A_00);
	endtask
	task t_set;
		step(fill_byte, 8'h12, 32'h06_FF_0A_00);
		bit_sel = 3'h5;
		step(set_bit, 8'h81, 32'h06_A1_0A_00);
		step(nibble_exchange, 8'hA5, 32'h06_5A_0A_00);
	endtask
	task t_refuse;
		u_mem.m = 8'h01;
		op = decrement_then_skip_zero;
		start = 1'b1;
		@(posedge clk);
		@(posedge clk);
		#1 start = 1'b0;
		chk({6'h00, discard_prefetch, done}, 8'h01);
		@(posedge clk);
		#1 chk(u_mem.m, 8'h00);
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 1000) begin
			failures++;
			report_and_stop;
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		#1 arst_n = 1'b1;
		t_sub;
		t_rot;
		t_skip;
		t_set;
		t_refuse;
		report_and_stop;
	end
endmodule
bind rssd_core rssd_monitor i_mon (.clk(clk), .arst_n(arst_n),
	.start(start), .op(op), .mem_rd_data(mem_rd_data), .imm(imm),
	.bit_sel(bit_sel), .acc(acc), .flags(flags), .mem_wr(mem_wr),
	.mem_wr_data(mem_wr_data), .discard_prefetch(discard_prefetch),
	.busy(busy), .done(done));
